// >>> design/sfs_status_regs.sv
// status register bank of a serial flash, reached by serial commands
`timescale 1ns/1ns
module sfs_status_regs #(
  parameter sfs_pkg::sfs_nv_s NV_INIT = sfs_pkg::NV_DEFAULT,
  parameter int ADDR_W = 26
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_cs_n_pin,
  input wire logic spi_sclk_pin,
  input wire logic spi_mosi_pin,
  input wire logic wp_n_pin,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic array_busy,
  output sfs_pkg::sfs_areq_s array_req,
  output logic suspend_req,
  output logic resume_req,
  output logic [3:0] dummy_cycles,
  output logic addr4_mode,
  output logic [2:0] secure_locked
);
  logic cs_n_s, sclk_s, mosi_s, wp_n_s;
  logic sclk_prev_q, sclk_prev_d, cs_prev_q, cs_prev_d, sclk_rise, ex_go;
  sfs_pkg::sfs_phase_e phase_q, phase_d;
  logic [2:0] bit_q, bit_d, abytes_q, abytes_d, addr_len;
  logic [1:0] dbytes_q, dbytes_d;
  logic [7:0] sh_q, sh_d, op_q, op_d, data_q, data_d, out_q, out_d, byte_v;
  logic [31:0] addr_q, addr_d, eff_addr;
  logic [7:0] sr1, sr2, sr3;
  sfs_pkg::sfs_nv_s nv_q, nv_d;
  logic wr_latch_q, wr_latch_d, addr4_q, addr4_d, erase_sus_q, erase_sus_d;
  logic prog_sus_q, prog_sus_d, armed_q, armed_d, erase_kind_q, erase_kind_d;
  logic susp_q, susp_d, res_q, res_d;
  logic [sfs_pkg::BUSY_W-1:0] busy_cnt_q, busy_cnt_d;
  logic [3:0] dummy_q, dummy_d;
  sfs_pkg::sfs_areq_s req_q, req_d;
  logic busy, guard_lock, is_wr, wr_go, addr_done, prot_hit, any_prot, sw_rst_go;

  // pins come from the host's domain
  sfs_pin_sync #(.INIT(1'b1)) u_cs (.sys_clk(sys_clk), .rst(rst), .pin(spi_cs_n_pin),
    .level(cs_n_s));
  sfs_pin_sync #(.INIT(1'b0)) u_sclk (.sys_clk(sys_clk), .rst(rst), .pin(spi_sclk_pin),
    .level(sclk_s));
  sfs_pin_sync #(.INIT(1'b0)) u_mosi (.sys_clk(sys_clk), .rst(rst), .pin(spi_mosi_pin),
    .level(mosi_s));
  sfs_pin_sync #(.INIT(1'b1)) u_wp (.sys_clk(sys_clk), .rst(rst), .pin(wp_n_pin),
    .level(wp_n_s));

  // 3-byte mode clears the upper eight address bits to zero
  assign eff_addr = addr4_q ? addr_q : {8'h00, addr_q[23:0]};
  sfs_protect_map #(.BLK_W(ADDR_W - 16)) u_prot (.bp(nv_q.bp), .complement(nv_q.complement),
    .blk(eff_addr[ADDR_W-1:16]), .hit(prot_hit), .any(any_prot));

  // register images as read by the host
  always_comb
  begin
    busy = array_busy | (busy_cnt_q != '0);
    sr1 = '0;
    sr1[sfs_pkg::SR1_BUSY_BIT] = busy;
    sr1[sfs_pkg::SR1_LATCH_BIT] = wr_latch_q;
    sr1[sfs_pkg::SR1_BP_LSB +: sfs_pkg::BP_W] = nv_q.bp;
    sr1[sfs_pkg::SR1_GUARD_LO_BIT] = nv_q.guard_lo;
    sr2 = '0;
    sr2[sfs_pkg::SR2_ADDR4_BIT] = addr4_q;
    sr2[sfs_pkg::SR2_QUAD_EN_BIT] = 1'b1;
    sr2[sfs_pkg::SR2_PROG_SUS_BIT] = prog_sus_q;
    sr2[sfs_pkg::SR2_LOCK_LSB +: sfs_pkg::LOCK_W] = nv_q.lock;
    sr2[sfs_pkg::SR2_GUARD_HI_BIT] = nv_q.guard_hi;
    sr2[sfs_pkg::SR2_ERASE_SUS_BIT] = erase_sus_q;
    sr3 = '0;
    sr3[sfs_pkg::SR3_DUMMY_LSB +: sfs_pkg::DUMMY_SEL_W] = nv_q.dummy_sel;
    sr3[sfs_pkg::SR3_COMPL_BIT] = nv_q.complement;
    sr3[sfs_pkg::SR3_PU_ADDR4_BIT] = nv_q.pu_addr4;
  end

  function automatic logic [7:0] stat_of(input logic [7:0] op, input logic [7:0] a,
    input logic [7:0] b, input logic [7:0] c);
    stat_of = (op == sfs_pkg::CMD_RD_STAT1) ? a : (op == sfs_pkg::CMD_RD_STAT2) ? b : c;
  endfunction

  // serial side: bytes are taken on sclk rise; read data also advances on the
  // rise, so the next bit is settled well before the host samples it
  always_comb
  begin
    sclk_rise = sclk_s & ~sclk_prev_q;
    sclk_prev_d = sclk_s;
    cs_prev_d = cs_n_s;
    // a frame cut before its opcode completed executes nothing, so a stale
    // opcode is never applied a second time
    ex_go = cs_n_s & ~cs_prev_q & (phase_q != sfs_pkg::PH_CMD);
    addr_len = addr4_q ? sfs_pkg::ADDR_BYTES_4 : sfs_pkg::ADDR_BYTES_3;
    byte_v = {sh_q[6:0], mosi_s};
    phase_d = phase_q;
    bit_d = bit_q;
    abytes_d = abytes_q;
    dbytes_d = dbytes_q;
    sh_d = sh_q;
    op_d = op_q;
    data_d = data_q;
    out_d = out_q;
    addr_d = addr_q;
    if (cs_n_s)
    begin
      phase_d = sfs_pkg::PH_CMD;
      bit_d = 3'h0;
      abytes_d = 3'h0;
      dbytes_d = 2'h0;
    end
    else if (sclk_rise)
    begin
      bit_d = bit_q + 3'h1;
      sh_d = byte_v;
      out_d = {out_q[6:0], 1'b0};
      if (bit_q == 3'h7)
      begin
        unique case (phase_q)
          sfs_pkg::PH_CMD:
          begin
            op_d = byte_v;
            case (byte_v)
              sfs_pkg::CMD_RD_STAT1, sfs_pkg::CMD_RD_STAT2, sfs_pkg::CMD_RD_STAT3:
              begin
                phase_d = sfs_pkg::PH_RDATA;
                out_d = stat_of(byte_v, sr1, sr2, sr3);
              end
              sfs_pkg::CMD_WR_STAT1, sfs_pkg::CMD_WR_STAT2, sfs_pkg::CMD_WR_STAT3:
                phase_d = sfs_pkg::PH_WDATA;
              sfs_pkg::CMD_PAGE_PROG, sfs_pkg::CMD_SECT_ERASE, sfs_pkg::CMD_BLK_ERASE:
                phase_d = sfs_pkg::PH_ADDR;
              default:
                phase_d = sfs_pkg::PH_SKIP;
            endcase
          end
          sfs_pkg::PH_ADDR:
          begin
            addr_d = {addr_q[23:0], byte_v};
            abytes_d = abytes_q + 3'h1;
            if (abytes_d == addr_len)
              phase_d = sfs_pkg::PH_SKIP;
          end
          sfs_pkg::PH_WDATA:
          begin
            data_d = byte_v;
            if (dbytes_q != 2'h3)
              dbytes_d = dbytes_q + 2'h1;
          end
          sfs_pkg::PH_RDATA:
            out_d = stat_of(op_q, sr1, sr2, sr3); // repeats the live value
          sfs_pkg::PH_SKIP:
            out_d = out_q;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      phase_q <= sfs_pkg::PH_CMD;
      bit_q <= 3'h0;
      abytes_q <= 3'h0;
      dbytes_q <= 2'h0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      data_q <= 8'h00;
      out_q <= 8'h00;
      addr_q <= 32'h0000_0000;
    end
    else
    begin
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q <= cs_prev_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      abytes_q <= abytes_d;
      dbytes_q <= dbytes_d;
      sh_q <= sh_d;
      op_q <= op_d;
      data_q <= data_d;
      out_q <= out_d;
      addr_q <= addr_d;
    end
  end

  // lock decode: guard 01 with pin low, 10 and 11 until power cycle
  assign guard_lock = nv_q.guard_hi | (nv_q.guard_lo & ~wp_n_s);
  assign is_wr = (op_q == sfs_pkg::CMD_WR_STAT1) | (op_q == sfs_pkg::CMD_WR_STAT2)
    | (op_q == sfs_pkg::CMD_WR_STAT3);
  // exactly one whole data byte, latch set, idle and not locked
  assign wr_go = ex_go & is_wr & wr_latch_q & ~busy & ~guard_lock & (dbytes_q == 2'h1)
    & (bit_q == 3'h0);
  assign addr_done = (abytes_q == addr_len);
  assign sw_rst_go = ex_go & (op_q == sfs_pkg::CMD_RST) & armed_q;

  // command execution at chip-select release
  always_comb
  begin
    nv_d = nv_q;
    wr_latch_d = wr_latch_q;
    addr4_d = addr4_q;
    erase_sus_d = erase_sus_q;
    prog_sus_d = prog_sus_q;
    armed_d = armed_q;
    erase_kind_d = erase_kind_q;
    susp_d = 1'b0;
    res_d = 1'b0;
    req_d = '0;
    busy_cnt_d = (busy_cnt_q != '0) ? busy_cnt_q - 1'b1 : busy_cnt_q;
    dummy_d = sfs_pkg::dummy_for(op_q, nv_q.dummy_sel);
    if (wr_go)
    begin
      wr_latch_d = 1'b0;
      busy_cnt_d = sfs_pkg::STAT_WRITE_CYC;
      case (op_q)
        sfs_pkg::CMD_WR_STAT1:
        begin
          nv_d.bp = data_q[sfs_pkg::SR1_BP_LSB +: sfs_pkg::BP_W];
          nv_d.guard_lo = data_q[sfs_pkg::SR1_GUARD_LO_BIT];
        end
        sfs_pkg::CMD_WR_STAT2:
        begin
          nv_d.guard_hi = data_q[sfs_pkg::SR2_GUARD_HI_BIT];
          nv_d.lock = nv_q.lock | data_q[sfs_pkg::SR2_LOCK_LSB +: sfs_pkg::LOCK_W];
        end
        default:
        begin
          nv_d.pu_addr4 = data_q[sfs_pkg::SR3_PU_ADDR4_BIT];
          nv_d.complement = data_q[sfs_pkg::SR3_COMPL_BIT];
          nv_d.dummy_sel = data_q[sfs_pkg::SR3_DUMMY_LSB +: sfs_pkg::DUMMY_SEL_W];
        end
      endcase
    end
    if (ex_go)
    begin
      armed_d = (op_q == sfs_pkg::CMD_RST_ENABLE);
      case (op_q)
        sfs_pkg::CMD_WR_ENABLE:
          wr_latch_d = ~busy | wr_latch_q;
        sfs_pkg::CMD_WR_DISABLE:
          wr_latch_d = busy & wr_latch_q;
        sfs_pkg::CMD_PAGE_PROG, sfs_pkg::CMD_SECT_ERASE, sfs_pkg::CMD_BLK_ERASE:
        begin
          if (wr_latch_q && !busy && addr_done && !prot_hit)
          begin
            req_d.valid = 1'b1;
            req_d.addr = eff_addr;
            req_d.op = (op_q == sfs_pkg::CMD_PAGE_PROG) ? sfs_pkg::OP_PROG
              : (op_q == sfs_pkg::CMD_SECT_ERASE) ? sfs_pkg::OP_SECT_ERASE
              : sfs_pkg::OP_BLK_ERASE;
            erase_kind_d = (op_q != sfs_pkg::CMD_PAGE_PROG);
            wr_latch_d = 1'b0;
          end
        end
        sfs_pkg::CMD_CHIP_ERASE:
        begin
          if (wr_latch_q && !busy && !any_prot)
          begin
            req_d.valid = 1'b1;
            req_d.op = sfs_pkg::OP_CHIP_ERASE;
            erase_kind_d = 1'b1;
            wr_latch_d = 1'b0;
          end
        end
        sfs_pkg::CMD_SUSPEND:
        begin
          if (array_busy)
          begin
            susp_d = 1'b1;
            erase_sus_d = erase_sus_q | erase_kind_q;
            prog_sus_d = prog_sus_q | ~erase_kind_q;
          end
        end
        sfs_pkg::CMD_RESUME:
        begin
          res_d = erase_sus_q | prog_sus_q;
          erase_sus_d = 1'b0;
          prog_sus_d = 1'b0;
        end
        sfs_pkg::CMD_RST:
        begin
          if (armed_q)
          begin
            erase_sus_d = 1'b0;
            prog_sus_d = 1'b0;
            wr_latch_d = 1'b0;
            addr4_d = nv_q.pu_addr4;
          end
        end
        sfs_pkg::CMD_ENTER_4B:
          addr4_d = 1'b1;
        sfs_pkg::CMD_EXIT_4B:
          addr4_d = 1'b0;
        default:
          armed_d = armed_d;
      endcase
    end
  end

  // power cycle: every flag back to its power-up value, guard 10 drops to 00
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      nv_q <= NV_INIT;
      wr_latch_q <= 1'b0;
      addr4_q <= NV_INIT.pu_addr4;
      erase_sus_q <= 1'b0;
      prog_sus_q <= 1'b0;
      armed_q <= 1'b0;
      erase_kind_q <= 1'b0;
      susp_q <= 1'b0;
      res_q <= 1'b0;
      req_q <= '0;
      busy_cnt_q <= '0;
      dummy_q <= 4'h0;
    end
    else
    begin
      nv_q <= nv_d;
      wr_latch_q <= wr_latch_d;
      addr4_q <= addr4_d;
      erase_sus_q <= erase_sus_d;
      prog_sus_q <= prog_sus_d;
      armed_q <= armed_d;
      erase_kind_q <= erase_kind_d;
      susp_q <= susp_d;
      res_q <= res_d;
      req_q <= req_d;
      busy_cnt_q <= busy_cnt_d;
      dummy_q <= dummy_d;
    end
  end

  assign spi_miso = out_q[7];
  assign spi_miso_oe_n = cs_n_s | (phase_q != sfs_pkg::PH_RDATA);
  assign array_req = req_q;
  assign suspend_req = susp_q;
  assign resume_req = res_q;
  assign dummy_cycles = dummy_q;
  assign addr4_mode = addr4_q;
  assign secure_locked = nv_q.lock;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  busy_after_write_a: assert property (wr_go |=> sr1[0] [*8])
    else $error("busy flag not high after register write");
  array_latch_a: assert property (req_q.valid |-> $past(wr_latch_q) && !wr_latch_q)
    else $error("array request without write latch");
  wr_refused_a: assert property (ex_go && is_wr && !wr_latch_q |=> $stable(nv_q))
    else $error("register changed with latch clear");
  prot_reject_a: assert property (req_q.valid && req_q.op != sfs_pkg::OP_CHIP_ERASE
    |-> !$past(prot_hit))
    else $error("request issued into protected region");
  hw_lock_a: assert property (ex_go && guard_lock |=> $stable(nv_q))
    else $error("register written while locked");
  chip_guard_a: assert property (req_q.valid && req_q.op == sfs_pkg::OP_CHIP_ERASE
    |-> !$past(any_prot))
    else $error("chip erase with protected region");
  soft_write_a: assert property (wr_go && op_q == sfs_pkg::CMD_WR_STAT3 |=>
    nv_q.dummy_sel == $past(data_q[1:0]) && sr3[7:5] == 3'h0)
    else $error("third register write not applied");
  guard_hi_a: assert property (nv_q.guard_hi |=> $stable(nv_q) [*2])
    else $error("guarded registers changed");
  addr_reset_a: assert property (sw_rst_go |=> addr4_q == $past(nv_q.pu_addr4)
    && sr2[0] == addr4_q)
    else $error("address mode not reloaded on reset");
  quad_fixed_a: assert property (sr2[1] && (sr3 & sfs_pkg::SR3_RSVD_MASK) == 8'h00)
    else $error("fixed bits wrong");
  suspend_flag_a: assert property (ex_go && op_q == sfs_pkg::CMD_SUSPEND && array_busy
    |=> suspend_req && (erase_sus_q == $past(erase_kind_q) || prog_sus_q))
    else $error("suspend flag not set");
  resume_clear_a: assert property (ex_go && op_q == sfs_pkg::CMD_RESUME
    |=> !erase_sus_q && !prog_sus_q)
    else $error("suspend flags not cleared");
  // the edge that still sees reset held compares against bits a power cycle dropped
  lock_sticky_a: assert property (!rst |->
    (nv_q.lock & $past(nv_q.lock)) == $past(nv_q.lock))
    else $error("one-time lock bit cleared");
  dummy_quad_a: assert property ((op_q == sfs_pkg::CMD_QUAD_IO_RD
    || op_q == sfs_pkg::CMD_QUAD_IO_RD_A4) && $stable(op_q) && $stable(nv_q)
    |-> dummy_q == (nv_q.dummy_sel[0] ? sfs_pkg::DUMMY_QUAD_HI : sfs_pkg::DUMMY_QUAD_LO))
    else $error("wrong dummy count");

  wr_accept_c: cover property (wr_go);
  suspend_c: cover property (susp_q);
  chip_erase_c: cover property (req_q.valid && req_q.op == sfs_pkg::OP_CHIP_ERASE);
  status_read_c: cover property (phase_q == sfs_pkg::PH_RDATA && sclk_rise);
endmodule // sfs_status_regs

// >>> pkg/sfs_pkg.sv
// shared constants, types and helpers of the serial flash status register bank
package sfs_pkg;

  // command opcodes
  localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  localparam logic [7:0] CMD_RD_STAT1 = 8'h05;
  localparam logic [7:0] CMD_RD_STAT2 = 8'h35;
  localparam logic [7:0] CMD_RD_STAT3 = 8'h15;
  localparam logic [7:0] CMD_WR_STAT1 = 8'h01;
  localparam logic [7:0] CMD_WR_STAT2 = 8'h31;
  localparam logic [7:0] CMD_WR_STAT3 = 8'h11;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLK_ERASE = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_RST_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  localparam logic [7:0] CMD_ENTER_4B = 8'hB7;
  localparam logic [7:0] CMD_EXIT_4B = 8'hE9;
  localparam logic [7:0] CMD_FAST_RD = 8'h0B;
  localparam logic [7:0] CMD_FAST_RD_A4 = 8'h0C;
  localparam logic [7:0] CMD_DUAL_OUT_RD = 8'h3B;
  localparam logic [7:0] CMD_DUAL_OUT_RD_A4 = 8'h3C;
  localparam logic [7:0] CMD_QUAD_OUT_RD = 8'h6B;
  localparam logic [7:0] CMD_QUAD_OUT_RD_A4 = 8'h6C;
  localparam logic [7:0] CMD_DUAL_IO_RD = 8'hBB;
  localparam logic [7:0] CMD_DUAL_IO_RD_A4 = 8'hBC;
  localparam logic [7:0] CMD_QUAD_IO_RD = 8'hEB;
  localparam logic [7:0] CMD_QUAD_IO_RD_A4 = 8'hEC;

  // status register bit positions, reserved mask and field widths
  localparam int SR1_BUSY_BIT = 0;
  localparam int SR1_LATCH_BIT = 1;
  localparam int SR1_BP_LSB = 2;
  localparam int SR1_GUARD_LO_BIT = 7;
  localparam int SR2_ADDR4_BIT = 0;
  localparam int SR2_QUAD_EN_BIT = 1;
  localparam int SR2_PROG_SUS_BIT = 2;
  localparam int SR2_LOCK_LSB = 3;
  localparam int SR2_GUARD_HI_BIT = 6;
  localparam int SR2_ERASE_SUS_BIT = 7;
  localparam int SR3_DUMMY_LSB = 0;
  localparam int SR3_COMPL_BIT = 3;
  localparam int SR3_PU_ADDR4_BIT = 4;
  localparam logic [7:0] SR3_RSVD_MASK = 8'hE4;
  localparam int BP_W = 5;
  localparam int BP_SIZE_W = 4;
  localparam int LOCK_W = 3;
  localparam int DUMMY_SEL_W = 2;

  // dummy cycle counts
  localparam logic [3:0] DUMMY_FIXED = 4'h8;
  localparam logic [3:0] DUMMY_DUAL_LO = 4'h4;
  localparam logic [3:0] DUMMY_DUAL_HI = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_LO = 4'h6;
  localparam logic [3:0] DUMMY_QUAD_HI = 4'hA;

  // address bytes per mode
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;

  // register write busy time
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_STAT_WRITE_NS = 5000;
  localparam int BUSY_W = 8;
  localparam logic [BUSY_W-1:0] STAT_WRITE_CYC = BUSY_W'(T_STAT_WRITE_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {OP_PROG, OP_SECT_ERASE, OP_BLK_ERASE, OP_CHIP_ERASE} sfs_op_e;
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_WDATA, PH_RDATA, PH_SKIP} sfs_phase_e;

  // non-volatile bits, kept in flip-flops
  typedef struct packed {
    logic guard_hi;
    logic guard_lo;
    logic [LOCK_W-1:0] lock;
    logic [BP_W-1:0] bp;
    logic complement;
    logic pu_addr4;
    logic [DUMMY_SEL_W-1:0] dummy_sel;
  } sfs_nv_s;

  localparam sfs_nv_s NV_DEFAULT = '0;

  // request to the array engine
  typedef struct packed {
    logic valid;
    sfs_op_e op;
    logic [31:0] addr;
  } sfs_areq_s;

  // dummy cycles for a read opcode, zero for anything else
  function automatic logic [3:0] dummy_for(input logic [7:0] op, input logic [1:0] sel);
    logic hi;
    hi = sel[0];
    case (op)
      CMD_FAST_RD, CMD_FAST_RD_A4, CMD_DUAL_OUT_RD, CMD_DUAL_OUT_RD_A4,
      CMD_QUAD_OUT_RD, CMD_QUAD_OUT_RD_A4: dummy_for = DUMMY_FIXED;
      CMD_DUAL_IO_RD, CMD_DUAL_IO_RD_A4: dummy_for = hi ? DUMMY_DUAL_HI : DUMMY_DUAL_LO;
      CMD_QUAD_IO_RD, CMD_QUAD_IO_RD_A4: dummy_for = hi ? DUMMY_QUAD_HI : DUMMY_QUAD_LO;
      default: dummy_for = 4'h0;
    endcase
  endfunction

endpackage

// >>> design/sfs_pin_sync.sv
// three-stage pin synchroniser; output moves once stages two and three agree
`timescale 1ns/1ns
module sfs_pin_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic [2:0] stg_q;
  logic [2:0] stg_d;
  logic level_q;
  logic level_d;

  // stage one feeds only stage two
  always_comb
  begin
    stg_d = {stg_q[1:0], pin};
    level_d = (stg_q[1] == stg_q[2]) ? stg_q[2] : level_q;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stg_q <= {3{INIT}};
      level_q <= INIT;
    end
    else
    begin
      stg_q <= stg_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule // sfs_pin_sync

// >>> design/sfs_protect_map.sv
// maps block-protect field and complement bit onto the array blocks
`timescale 1ns/1ns
module sfs_protect_map #(
  parameter int BLK_W = 10
) (
  input wire logic [sfs_pkg::BP_W-1:0] bp,
  input wire logic complement,
  input wire logic [BLK_W-1:0] blk,
  output logic hit,
  output logic any
);
  localparam logic [BLK_W:0] FULL = {1'b1, {BLK_W{1'b0}}};
  localparam logic [BLK_W:0] ONE = {{BLK_W{1'b0}}, 1'b1};
  logic [sfs_pkg::BP_SIZE_W-1:0] size_sel;
  logic [BLK_W:0] cnt;
  logic region;

  // low bits give a power-of-two region size, top bit picks bottom or top end
  always_comb
  begin
    size_sel = bp[sfs_pkg::BP_SIZE_W-1:0];
    if (size_sel == '0)
      cnt = '0;
    else if (int'(size_sel) > BLK_W)
      cnt = FULL;
    else
      cnt = ONE << (size_sel - 4'h1);
    if (bp[sfs_pkg::BP_W-1])
      region = {1'b0, blk} < cnt;
    else
      region = {1'b0, blk} >= (FULL - cnt);
    hit = region ^ complement;
    any = complement ? (cnt != FULL) : (cnt != '0);
  end
endmodule // sfs_protect_map

// >>> bench/sfs_host_model.sv
// host serial controller model that drives command frames
`timescale 1ns/1ns
module sfs_host_model (
  input wire logic sys_clk,
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  // four sys_clk per half period gives the 320 ns link clock
  localparam int HALF = 4;
  // deselected, clock parked low outside frames (mode 0)
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // opcode then nb bytes of pay, msb first; the last eight rises fill rd;
  // pins move just after a sys_clk edge, so the pin path never races them;
  // addresses stay inside the lowest segment
  task automatic frame(input logic [7:0] op, input int nb, input logic [31:0] pay,
    output logic [7:0] rd);
    logic [39:0] sh;
    sh = {op, pay};
    rd = 8'h00;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    for (int i = 0; i < 8 * nb + 8; i++)
    begin
      mosi <= sh[39 - i];
      repeat (HALF) @(posedge sys_clk);
      sclk <= 1'b1;
      rd = {rd[6:0], miso};
      repeat (HALF) @(posedge sys_clk);
      sclk <= 1'b0;
    end
    mosi <= ~mosi; // a released line must not keep its last value
    repeat (HALF) @(posedge sys_clk);
    cs_n <= 1'b1;
    repeat (6 * HALF) @(posedge sys_clk);
  endtask
endmodule // sfs_host_model

// >>> bench/testbench.sv
// self-checking bench of the status register bank
`timescale 1ns/1ns
module testbench;
  logic sys_clk, rst, cs_n, sclk, mosi, wp_n, busy, miso, oe_n, sus, res, addr4;
  logic [1:0] last_op;
  logic [3:0] dummy;
  logic [2:0] locked;
  logic [7:0] rd;
  sfs_pkg::sfs_areq_s req;
  int num_errors = 0;
  int check_count = 0;
  int n_req = 0;
  int n_sus = 0;
  int n_res = 0;
  int n_oe = 0;
  sfs_host_model host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
  sfs_status_regs DUT (.sys_clk(sys_clk), .rst(rst), .spi_cs_n_pin(cs_n), .spi_sclk_pin(sclk),
    .spi_mosi_pin(mosi), .wp_n_pin(wp_n), .spi_miso(miso), .spi_miso_oe_n(oe_n),
    .array_busy(busy), .array_req(req), .suspend_req(sus), .resume_req(res),
    .dummy_cycles(dummy), .addr4_mode(addr4), .secure_locked(locked));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // launch, suspend and resume are one-cycle pulses, so they are counted here
  always @(posedge sys_clk)
  begin
    if (req.valid === 1'b1)
      n_req <= n_req + 1;
    if (req.valid === 1'b1)
      last_op <= req.op;
    if (sus === 1'b1)
      n_sus <= n_sus + 1;
    if (res === 1'b1)
      n_res <= n_res + 1;
    if (oe_n === 1'b0)
      n_oe <= n_oe + 1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame(op, 0, 32'h0, rd);
  endtask
  // enable, one data byte, then outwait the register write time
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    cmd(8'h06);
    host.frame(op, 1, {d, 24'h0}, rd);
    repeat (140) @(posedge sys_clk);
  endtask
  task automatic rsr(input logic [7:0] op, input logic [7:0] exp);
    host.frame(op, 1, 32'h0, rd);
    check(rd, exp);
  endtask
  task automatic reset_state();
    rsr(8'h35, 8'h02);
    check({7'h00, n_oe != 0}, 8'h01);
    rsr(8'h15, 8'h00);
    check({7'h00, addr4}, 8'h00);
    host.frame(8'h01, 1, 32'h1C00_0000, rd);
    rsr(8'h05, 8'h00);
  endtask
  // busy read back at once; then the guard bit with the pin low and high
  task automatic write_guard();
    cmd(8'h06);
    rsr(8'h05, 8'h02);
    host.frame(8'h01, 1, 32'h9C00_0000, rd);
    rsr(8'h05, 8'h9D);
    rsr(8'h05, 8'h9C);
    @(posedge sys_clk) wp_n <= 1'b0;
    wr(8'h01, 8'h00);
    rsr(8'h05, 8'h9E);
    @(posedge sys_clk) wp_n <= 1'b1;
    wr(8'h01, 8'h00);
    rsr(8'h05, 8'h00);
  endtask
  task automatic addr_and_dummy();
    logic [7:0] op [4] = '{8'h0B, 8'h6C, 8'hBB, 8'hEC};
    logic [3:0] ex [8] = '{4'h8, 4'h8, 4'h4, 4'h6, 4'h8, 4'h8, 4'h8, 4'hA};
    cmd(8'hB7);
    rsr(8'h35, 8'h03);
    cmd(8'hE9);
    check({7'h00, addr4}, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4)
        wr(8'h11, 8'hE5);
      cmd(op[i % 4]);
      check({4'h0, dummy}, {4'h0, ex[i]});
    end
    rsr(8'h15, 8'h01);
  endtask
  // bottom block guarded: sector and chip erase refused; then erase, chip
  // erase, suspend, resume, program, a second suspend and the software reset pair
  task automatic erase_suspend();
    wr(8'h01, 8'h44);
    cmd(8'h06);
    host.frame(8'h20, 3, 32'h0010_0000, rd);
    cmd(8'hC7);
    check(8'(n_req), 8'h00);
    wr(8'h01, 8'h00);
    cmd(8'h06);
    host.frame(8'h20, 3, 32'h0010_0000, rd);
    check({6'h00, last_op}, 8'h01);
    cmd(8'h06);
    cmd(8'hC7);
    check({6'h00, last_op}, 8'h03);
    @(posedge sys_clk) busy <= 1'b1;
    cmd(8'h75);
    rsr(8'h35, 8'h82);
    cmd(8'h7A);
    rsr(8'h35, 8'h02);
    check(8'(n_sus), 8'h01);
    check(8'(n_res), 8'h01);
    @(posedge sys_clk) busy <= 1'b0;
    cmd(8'h06);
    host.frame(8'h02, 4, 32'h0010_00A5, rd);
    check(8'(n_req), 8'h03);
    @(posedge sys_clk) busy <= 1'b1;
    cmd(8'h75);
    cmd(8'hB7);
    rsr(8'h35, 8'h07);
    cmd(8'h66);
    cmd(8'h99);
    rsr(8'h35, 8'h02);
    @(posedge sys_clk) busy <= 1'b0;
  endtask
  // lock bit sticks; lockdown holds until a power cycle
  task automatic lockdown();
    wr(8'h31, 8'h08);
    wr(8'h31, 8'h00);
    check({5'h00, locked}, 8'h01);
    wr(8'h31, 8'h40);
    wr(8'h01, 8'h1C);
    rsr(8'h05, 8'h02);
    @(posedge sys_clk) rst <= 1'b1;
    @(posedge sys_clk) rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rsr(8'h35, 8'h02);
  endtask
  initial
  begin
    {rst, wp_n, busy} = 3'h6;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_state();
    write_guard();
    addr_and_dummy();
    erase_suspend();
    lockdown();
    close_out();
  end
endmodule // testbench
